//--- hdl/line_mon_pkg.sv
package line_mon_pkg;

	// Monitor converter pacing
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SAMPLE_HZ = 800;
	localparam int unsigned SAMPLE_CYCLES_DEF = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned TICK_W = 20;

	// Direct register addresses
	localparam logic [7:0] ADDR_IRQ_PEND = 8'h13;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h16;
	localparam logic [7:0] ADDR_IND_DATA_LO = 8'h1c;
	localparam logic [7:0] ADDR_IND_DATA_HI = 8'h1d;
	localparam logic [7:0] ADDR_IND_WRITE = 8'h1e;
	localparam logic [7:0] ADDR_IND_READ = 8'h1f;
	localparam logic [7:0] ADDR_LINEFEED = 8'h40;
	localparam logic [7:0] ADDR_AUTO_OPEN = 8'h43;
	localparam logic [7:0] ADDR_CLOSURE_STATUS = 8'h44;
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h45;
	localparam logic [7:0] ADDR_PWR_SEL = 8'h4c;
	localparam logic [7:0] ADDR_PWR_OUT = 8'h4d;
	localparam logic [7:0] ADDR_LOOP_CURRENT = 8'h4f;
	localparam logic [7:0] ADDR_CLOSURE_MODE = 8'h6c;

	// Indirect register addresses
	localparam logic [7:0] IND_THR_HIGH = 8'h0f;
	localparam logic [7:0] IND_PWR_LIM_A = 8'h13;
	localparam logic [7:0] IND_PWR_LIM_B = 8'h14;
	localparam logic [7:0] IND_PWR_LIM_C = 8'h15;
	localparam logic [7:0] IND_CLOSURE_COEF = 8'h16;
	localparam logic [7:0] IND_POLE_A = 8'h18;
	localparam logic [7:0] IND_POLE_B = 8'h19;
	localparam logic [7:0] IND_POLE_C = 8'h1a;
	localparam logic [7:0] IND_THR_LOW = 8'h42;

	// Field positions
	localparam int unsigned PEND_LC_BIT = 1;
	localparam int unsigned PEND_Q_LSB = 2;
	localparam logic [7:0] PEND_USED = 8'hfe;
	localparam int unsigned HYST_BIT = 0;
	localparam int unsigned VMODE_BIT = 2;
	localparam int unsigned AUTO_OPEN_BIT = 0;
	localparam int unsigned LFS_LSB = 4;
	localparam int unsigned NUM_Q = 6;

	// Linefeed codes
	localparam logic [2:0] LF_OPEN = 3'h0;
	localparam logic [2:0] LF_FWD_ACTIVE = 3'h1;
	localparam logic [2:0] LF_FWD_OHT = 3'h2;
	localparam logic [2:0] LF_REV_ACTIVE = 3'h5;
	localparam logic [2:0] LF_REV_OHT = 3'h6;

	// Filter fixed point
	localparam int unsigned FILT_FRAC = 8;
	localparam int unsigned POLE_SHIFT = 8;
	localparam int unsigned COEF_SHIFT = 13;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [5:0][7:0] q_power;
		logic [6:0] loop_current;
		logic [7:0] loop_voltage;
	} sense_t;

	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic [7:0] rdata;
		logic [7:0] pend;
		logic [7:0] en;
		logic [2:0] lf;
		logic auto_open;
		logic [6:0] debounce_time;
		logic [2:0] selector;
		logic hyst_on;
		logic voltage_mode;
		logic [7:0] power_value;
		logic [6:0] loop_current_value;
		logic [15:0] ind_data;
		logic [15:0] thr_high;
		logic [15:0] thr_low;
		logic [12:0] filter_coeff;
		logic [2:0][7:0] power_limit;
		logic [2:0][7:0] thermal_pole;
		logic [5:0][15:0] pwr_filt;
		logic [15:0] lc_filt;
		logic cmp;
		logic closure_status;
		logic [6:0] db_cnt;
	} mon_state_t;

	localparam mon_state_t STATE_RESET = '0;

endpackage

//--- hdl/line_power_loop_monitor.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module line_power_loop_monitor
	import line_mon_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input reg_req_t bus,
	output logic [7:0] rdata,
	input sense_t sense,
	output logic irq,
	output logic [2:0] linefeed_state,
	output logic closure_detected
);

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);

	mon_state_t st;
	mon_state_t nx;
	logic tick;
	logic on_hook;
	logic [5:0][15:0] pwr_step;
	logic [5:0] q_alarm;
	logic [6:0] lc_in;
	logic signed [17:0] lc_diff;
	logic signed [31:0] lc_prod;
	logic signed [17:0] lc_sum;
	logic [6:0] lc_level;
	logic above_high;
	logic below_high;
	logic below_low;
	logic cmp_new;

	assign tick = (st.tick_cnt == TICK_LAST);

	assign on_hook = (st.lf == LF_FWD_ACTIVE) || (st.lf == LF_FWD_OHT) ||
		(st.lf == LF_REV_ACTIVE) || (st.lf == LF_REV_OHT);

	// Per-transistor thermal filter and limit compare
	for (genvar gi = 0; gi < NUM_Q; gi++)
	begin : g_q
		logic signed [17:0] p_diff;
		logic signed [26:0] p_prod;
		logic signed [17:0] p_sum;
		assign p_diff = $signed({2'b00, 16'(sense.q_power[gi]) << FILT_FRAC}) -
			$signed({2'b00, st.pwr_filt[gi]});
		assign p_prod = p_diff * $signed({1'b0, st.thermal_pole[gi / 2]});
		assign p_sum = $signed({2'b00, st.pwr_filt[gi]}) + 18'(p_prod >>> POLE_SHIFT);
		assign pwr_step[gi] = p_sum[15:0];
		assign q_alarm[gi] = st.pwr_filt[gi][FILT_FRAC +: 8] > st.power_limit[gi / 2];
	end

	// voltage or current as loop measure
	assign lc_in = st.voltage_mode ? sense.loop_voltage[6:0] : {1'b0, sense.loop_current[5:0]};

	assign lc_diff = $signed({2'b00, 16'(lc_in) << FILT_FRAC}) - $signed({2'b00, st.lc_filt});
	assign lc_prod = lc_diff * $signed({1'b0, st.filter_coeff});
	assign lc_sum = $signed({2'b00, st.lc_filt}) + 18'(lc_prod >>> COEF_SHIFT);
	assign lc_level = st.lc_filt[FILT_FRAC +: 7];

	assign above_high = lc_level > st.thr_high[6:0];
	assign below_high = lc_level < st.thr_high[6:0];
	assign below_low = lc_level < st.thr_low[6:0];

	always_comb
	begin
		cmp_new = st.cmp;
		if (!st.voltage_mode)
		begin
			if (!st.hyst_on)
				cmp_new = above_high;
			else if (above_high)
				cmp_new = 1'b1;
			else if (below_low)
				cmp_new = 1'b0;
		end
		else
		begin
			if (!st.hyst_on)
				cmp_new = below_high;
			// below lower closes, above upper opens
			else if (below_low)
				cmp_new = 1'b1;
			else if (above_high)
				cmp_new = 1'b0;
		end
	end

	// Indirect register readback
	function automatic logic [15:0] ind_read(input mon_state_t s, input logic [7:0] a);
		logic [15:0] v;
		v = '0;
		unique case (a)
			IND_THR_HIGH: v = s.thr_high;
			IND_THR_LOW: v = s.thr_low;
			IND_CLOSURE_COEF: v = 16'(s.filter_coeff);
			IND_PWR_LIM_A: v = 16'(s.power_limit[0]);
			IND_PWR_LIM_B: v = 16'(s.power_limit[1]);
			IND_PWR_LIM_C: v = 16'(s.power_limit[2]);
			IND_POLE_A: v = 16'(s.thermal_pole[0]);
			IND_POLE_B: v = 16'(s.thermal_pole[1]);
			IND_POLE_C: v = 16'(s.thermal_pole[2]);
			default: v = '0;
		endcase
		return v;
	endfunction

	// Next-state of the whole block
	always_comb
	begin
		nx = st;
		nx.tick_cnt = tick ? '0 : st.tick_cnt + TICK_W'(1);
		nx.rdata = '0;

		// Register reads, data valid the cycle after
		if (bus.rd)
		begin
			unique case (bus.addr)
				ADDR_IRQ_PEND: nx.rdata = st.pend;
				ADDR_IRQ_EN: nx.rdata = st.en;
				ADDR_IND_DATA_LO: nx.rdata = st.ind_data[7:0];
				ADDR_IND_DATA_HI: nx.rdata = st.ind_data[15:8];
				// shadow field mirrors the applied state
				ADDR_LINEFEED: nx.rdata = 8'(st.lf) |
					(8'(st.lf) << LFS_LSB);
				ADDR_AUTO_OPEN: nx.rdata = 8'(st.auto_open) << AUTO_OPEN_BIT;
				ADDR_CLOSURE_STATUS: nx.rdata = 8'(st.closure_status);
				ADDR_DEBOUNCE: nx.rdata = 8'(st.debounce_time);
				ADDR_PWR_SEL: nx.rdata = 8'(st.selector);
				ADDR_PWR_OUT: nx.rdata = st.power_value;
				ADDR_LOOP_CURRENT: nx.rdata = 8'(st.loop_current_value);
				ADDR_CLOSURE_MODE: nx.rdata = (8'(st.hyst_on) << HYST_BIT) |
					(8'(st.voltage_mode) << VMODE_BIT);
				default: nx.rdata = '0;
			endcase
		end

		// Register writes; pending bits clear on one
		if (bus.wr)
		begin
			unique case (bus.addr)
				ADDR_IRQ_PEND: nx.pend = st.pend & ~bus.wdata;
				ADDR_IRQ_EN: nx.en = bus.wdata & PEND_USED;
				ADDR_IND_DATA_LO: nx.ind_data[7:0] = bus.wdata;
				ADDR_IND_DATA_HI: nx.ind_data[15:8] = bus.wdata;
				ADDR_IND_WRITE:
				begin
					unique case (bus.wdata)
						IND_THR_HIGH: nx.thr_high = st.ind_data;
						IND_THR_LOW: nx.thr_low = st.ind_data;
						IND_CLOSURE_COEF: nx.filter_coeff = st.ind_data[12:0];
						IND_PWR_LIM_A: nx.power_limit[0] = st.ind_data[7:0];
						IND_PWR_LIM_B: nx.power_limit[1] = st.ind_data[7:0];
						IND_PWR_LIM_C: nx.power_limit[2] = st.ind_data[7:0];
						IND_POLE_A: nx.thermal_pole[0] = st.ind_data[7:0];
						IND_POLE_B: nx.thermal_pole[1] = st.ind_data[7:0];
						IND_POLE_C: nx.thermal_pole[2] = st.ind_data[7:0];
						default: nx.ind_data = st.ind_data;
					endcase
				end
				ADDR_IND_READ: nx.ind_data = ind_read(st, bus.wdata);
				ADDR_LINEFEED: nx.lf = bus.wdata[2:0];
				ADDR_AUTO_OPEN: nx.auto_open = bus.wdata[AUTO_OPEN_BIT];
				ADDR_DEBOUNCE: nx.debounce_time = bus.wdata[6:0];
				ADDR_PWR_SEL: nx.selector = bus.wdata[2:0];
				ADDR_CLOSURE_MODE:
				begin
					nx.hyst_on = bus.wdata[HYST_BIT];
					nx.voltage_mode = bus.wdata[VMODE_BIT];
				end
				default: nx.rdata = nx.rdata;
			endcase
		end

		// Power path, one step per sample; alarms set after clears so set wins
		if (tick)
		begin
			nx.pwr_filt = pwr_step;
			nx.loop_current_value = sense.loop_current;
			nx.power_value = (st.selector < 3'(NUM_Q)) ? sense.q_power[st.selector] : '0;
			// transistor n to pending bit n+2
			nx.pend[PEND_Q_LSB +: NUM_Q] = nx.pend[PEND_Q_LSB +: NUM_Q] | q_alarm;
			if (st.auto_open && (|q_alarm))
				nx.lf = LF_OPEN;
		end

		// Loop closure chain, frozen outside on-hook states
		// no detection outside on-hook states
		if (tick && on_hook)
		begin
			nx.lc_filt = lc_sum[15:0];
			nx.cmp = cmp_new;
			// change only after full opposite interval
			if (cmp_new == st.closure_status)
				nx.db_cnt = '0;
			else if (st.db_cnt >= st.debounce_time)
			begin
				nx.closure_status = cmp_new;
				nx.db_cnt = '0;
				if (cmp_new)
					nx.pend[PEND_LC_BIT] = 1'b1;
			end
			else
				nx.db_cnt = st.db_cnt + 7'(1);
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			st <= STATE_RESET;
		else
			st <= nx;
	end

	assign irq = |(st.pend & st.en);
	assign rdata = st.rdata;
	assign linefeed_state = st.lf;
	assign closure_detected = st.closure_status;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_power_readout: assert property (tick && st.selector < 3'(NUM_Q) |=>
		st.power_value == $past(sense.q_power[st.selector]))
		else $error("power value not the selected sample");

	a_alarm_pending: assert property (tick && (|q_alarm) |=>
		(st.pend[PEND_Q_LSB +: NUM_Q] & $past(q_alarm)) == $past(q_alarm))
		else $error("alarm did not set pending bit");

	a_auto_open_forced: assert property (tick && (|q_alarm) && st.auto_open |=>
		st.lf == LF_OPEN)
		else $error("auto open did not force Open");

	a_manual_lf_hold: assert property (tick && (|q_alarm) && !st.auto_open &&
		!bus.wr |=> $stable(st.lf))
		else $error("linefeed changed in manual mode");

	a_offhook_gated: assert property (!on_hook |=>
		$stable(st.lc_filt) && $stable(st.closure_status))
		else $error("closure chain moved outside on-hook");

	a_debounce_full: assert property ($changed(st.closure_status) |->
		$past(st.db_cnt) >= $past(st.debounce_time) && $past(tick))
		else $error("status changed before interval");

	a_closure_pending: assert property ($rose(st.closure_status) |->
		st.pend[PEND_LC_BIT])
		else $error("closure without pending bit");

	a_irq_enable_gate: assert property (st.pend[PEND_LC_BIT] &&
		!st.en[PEND_LC_BIT] && (st.pend[7:2] & st.en[7:2]) == '0 |-> !irq)
		else $error("irq without an enabled pending bit");

	a_hyst_window: assert property (tick && on_hook && st.hyst_on &&
		!st.voltage_mode && !above_high && !below_low |=> $stable(st.cmp))
		else $error("comparator moved inside window");

	a_read_latency: assert property (bus.rd && bus.addr == ADDR_CLOSURE_STATUS |=>
		rdata == 8'($past(st.closure_status)) ##1 rdata == '0 || $past(bus.rd))
		else $error("status read data misplaced");

	a_tick_wrap: assert property (tick |=>
		st.tick_cnt == '0)
		else $error("sample counter did not wrap");

	a_idle_rdata: assert property (!bus.rd |=>
		rdata == '0)
		else $error("read data outside its cycle");

	a_enable_write: assert property (bus.wr && bus.addr == ADDR_IRQ_EN |=>
		st.en == ($past(bus.wdata) & PEND_USED))
		else $error("enable register not as written");

	a_pend_sticky: assert property (!(bus.wr && bus.addr == ADDR_IRQ_PEND) |=>
		(st.pend & $past(st.pend)) == $past(st.pend))
		else $error("pending bit dropped without a clear");

	a_pend_on_tick: assert property (!tick && !bus.wr |=>
		$stable(st.pend))
		else $error("pending changed between samples");

	a_power_hold: assert property (!tick |=>
		$stable(st.power_value))
		else $error("power value changed between samples");

	a_select_range: assert property (tick && st.selector >= 3'(NUM_Q) |=>
		st.power_value == '0)
		else $error("out of range selector not zero");

	a_debounce_restart: assert property (tick && on_hook && cmp_new == st.closure_status |=>
		st.db_cnt == '0)
		else $error("debounce count not restarted");

	a_loop_compare: assert property (tick && on_hook && !st.hyst_on && !st.voltage_mode |=>
		st.cmp == $past(above_high))
		else $error("current comparator wrong");

	a_voltage_compare: assert property (tick && on_hook && !st.hyst_on && st.voltage_mode |=>
		st.cmp == $past(below_high))
		else $error("voltage comparator wrong");

	a_linefeed_write: assert property (bus.wr && bus.addr == ADDR_LINEFEED &&
		!(tick && st.auto_open && (|q_alarm)) |=> st.lf == $past(bus.wdata[2:0]))
		else $error("linefeed write lost");

endmodule // line_power_loop_monitor

//--- verif/line_sense_model.sv
`timescale 1ns/100ps
module line_sense_model
	import line_mon_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [5:0][7:0] pwr_set,
	input wire logic off_hook,
	output sense_t sense
);
	// Line and transistors, changed only on clock edges
	// Off-hook draws loop current and collapses loop voltage
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sense <= '0;
		end
		else
		begin
			sense.q_power <= pwr_set;
			sense.loop_current <= off_hook ? 7'h14 : 7'h00;
			sense.loop_voltage <= off_hook ? 8'h02 : 8'h30;
		end
	end
endmodule // line_sense_model

//--- verif/line_power_and_loop_closure_monitor_tb.sv
`timescale 1ns/100ps
module line_power_and_loop_closure_monitor_tb;
	import line_mon_pkg::*;
	// Short tick keeps the run small
	localparam int unsigned SC = 8;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	reg_req_t bus = '0;
	logic [7:0] rdata;
	sense_t sense;
	logic irq;
	logic [2:0] linefeed_state;
	logic closure_detected;
	logic [5:0][7:0] pwr_set = '0;
	logic off_hook = 1'b0;
	logic rd_prev = 1'b0;
	logic [7:0] exp_q[$];
	string name_q[$];
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] rng = 32'hdc91;
	logic [3:0][7:0] modes = {8'h05, 8'h01, 8'h04, 8'h00};

	// Free-running bench clock
	always #2 ref_clk = ~ref_clk;

	line_power_loop_monitor #(.SAMPLE_CYCLES(SC)) u_line_power_loop_monitor (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.bus(bus),
		.rdata(rdata),
		.sense(sense),
		.irq(irq),
		.linefeed_state(linefeed_state),
		.closure_detected(closure_detected)
	);

	line_sense_model u_line_sense_model (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pwr_set(pwr_set),
		.off_hook(off_hook),
		.sense(sense)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Read data only stands in the cycle after the strobe
	always @(posedge ref_clk)
	begin
		rd_prev <= bus.rd;
		if (rd_prev === 1'b1)
			check(name_q.pop_front(), exp_q.pop_front(), rdata);
	end

	// Hang guard: generous against roughly 1600 expected cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
	endtask

	// Low byte, high byte, then the trigger stores as many bits as the target register holds
	task automatic ind_wr(input logic [7:0] ia, input logic [15:0] v);
		wr(ADDR_IND_DATA_LO, v[7:0]);
		wr(ADDR_IND_DATA_HI, v[15:8]);
		wr(ADDR_IND_WRITE, ia);
	endtask

	// Only the low byte is kept, so the high byte reads zero
	task automatic ind_rd(input logic [7:0] ia, input logic [7:0] e);
		wr(ADDR_IND_READ, ia);
		rd(ADDR_IND_DATA_LO, e, "indirect_low");
		rd(ADDR_IND_DATA_HI, 8'h00, "indirect_high");
	endtask

	task automatic ticks(input int n);
		repeat (n * SC) @(posedge ref_clk);
	endtask

	task automatic pins(input logic i, input logic [2:0] lf, input logic c);
		@(negedge ref_clk);
		check("irq", {7'h00, i}, {7'h00, irq});
		check("linefeed_state", {5'h00, lf}, {5'h00, linefeed_state});
		check("closure_detected", {7'h00, c}, {7'h00, closure_detected});
		// Back on a rising edge so later drives stay edge aligned
		@(posedge ref_clk);
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		pins(1'b0, LF_OPEN, 1'b0);
		wr(ADDR_IRQ_EN, 8'hff);
		rd(ADDR_IRQ_EN, 8'hfe, "irq_enable");
		wr(ADDR_DEBOUNCE, 8'hff);
		rd(ADDR_DEBOUNCE, 8'h7f, "debounce");
		rd(8'h00, 8'h00, "unmapped");
		wr(ADDR_IRQ_EN, 8'h00);
		ind_wr(IND_PWR_LIM_B, 16'h1234);
		ind_rd(IND_PWR_LIM_B, 8'h34);
		ind_wr(IND_POLE_C, 16'h0000);
		ind_rd(8'h77, 8'h00);
		$display("registers test done");
		for (int i = 0; i < 6; i++)
		begin
			rng = xs(rng);
			pwr_set[i] <= rng[7:0];
		end
		for (int s = 0; s < 7; s++)
		begin
			wr(ADDR_PWR_SEL, 8'(s));
			ticks(2);
			rd(ADDR_PWR_OUT, (s < 6) ? pwr_set[s] : 8'h00, "power_value");
		end
		$display("power monitor test done");
		ind_wr(IND_CLOSURE_COEF, 16'h1fff);
		ind_wr(IND_THR_HIGH, 16'h000a);
		ind_wr(IND_THR_LOW, 16'h0005);
		wr(ADDR_DEBOUNCE, 8'h02);
		wr(ADDR_IRQ_EN, 8'h02);
		off_hook <= 1'b1;
		ticks(15);
		pins(1'b0, LF_OPEN, 1'b0);
		wr(ADDR_LINEFEED, {5'h00, LF_FWD_ACTIVE});
		rd(ADDR_LINEFEED, {1'b0, LF_FWD_ACTIVE, 1'b0, LF_FWD_ACTIVE}, "linefeed");
		for (int m = 0; m < 4; m++)
		begin
			wr(ADDR_CLOSURE_MODE, modes[m]);
			off_hook <= 1'b0;
			ticks(15);
			wr(ADDR_IRQ_PEND, 8'hff);
			pins(1'b0, LF_FWD_ACTIVE, 1'b0);
			off_hook <= 1'b1;
			ticks(2);
			pins(1'b0, LF_FWD_ACTIVE, 1'b0);
			ticks(13);
			pins(1'b1, LF_FWD_ACTIVE, 1'b1);
			rd(ADDR_CLOSURE_STATUS, 8'h01, "closure_status");
			rd(ADDR_LOOP_CURRENT, 8'h14, "loop_current");
			rd(ADDR_CLOSURE_MODE, modes[m], "closure_mode");
			rd(ADDR_IRQ_PEND, 8'h02, "closure_pending");
		end
		// Back to the preferred current-based detection
		wr(ADDR_CLOSURE_MODE, 8'h00);
		off_hook <= 1'b0;
		ticks(15);
		$display("loop closure test done");
		wr(ADDR_IRQ_PEND, 8'hff);
		rng = xs(rng);
		pwr_set[0] <= 8'h80 | rng[7:0];
		pwr_set[1] <= 8'h00;
		ind_wr(IND_POLE_A, 16'h00ff);
		ind_wr(IND_PWR_LIM_A, 16'h0010);
		wr(ADDR_AUTO_OPEN, 8'h01);
		wr(ADDR_IRQ_EN, 8'h04);
		ticks(12);
		pins(1'b1, LF_OPEN, 1'b0);
		rd(ADDR_IRQ_PEND, 8'h04, "alarm_pending");
		rd(ADDR_AUTO_OPEN, 8'h01, "auto_open");
		wr(ADDR_IRQ_EN, 8'h00);
		pins(1'b0, LF_OPEN, 1'b0);
		$display("power alarm test done");
		end_sim();
	end
endmodule // line_power_and_loop_closure_monitor_tb
